/* core/aio_pkg.sv */
// package: register offsets, field positions and reset values of the analog io control slice
package aio_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [4:0] AIO_OFF_OUT1_LOW = 5'h0E;
   localparam logic [4:0] AIO_OFF_OUT1_HIGH = 5'h0F;
   localparam logic [4:0] AIO_OFF_UPDATE_CFG = 5'h10;
   localparam logic [4:0] AIO_OFF_TRIGGER_CFG = 5'h11;
   localparam logic [4:0] AIO_OFF_STATUS = 5'h12;
   localparam logic [4:0] AIO_OFF_INT = 5'h13;
   localparam logic [4:0] AIO_OFF_PORT_A = 5'h14;
   localparam logic [4:0] AIO_OFF_PORT_B = 5'h15;
   localparam logic [4:0] AIO_OFF_UNUSED = 5'h16;
   localparam logic [4:0] AIO_OFF_DIR_CFG = 5'h17;
   // ****************************************
   // field positions
   // ****************************************
   localparam int AIO_BIT_SIMULT = 0;
   localparam int AIO_BIT_EDGE = 3;
   localparam int AIO_BIT_CLKSEL = 4;
   localparam int AIO_BIT_SCAN = 2;
   localparam int AIO_BIT_QUAL = 7;
   localparam int AIO_BIT_DIR_A = 4;
   localparam int AIO_BIT_DIR_B = 1;
   localparam int AIO_CAUSE_LSB = 4;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [11:0] AIO_RST_CODE = 12'h000;
   localparam logic [7:0] AIO_RST_PORT = 8'h00;
   localparam logic [3:0] AIO_RST_INT_EN = 4'h0;
   localparam logic [4:0] AIO_RST_TRIG = 5'h00;
   localparam logic AIO_RST_DIR = 1'b1;
   // ****************************************
   // trigger source codes
   // ****************************************
   typedef enum logic [1:0] {
      AIO_SRC_SOFTWARE = 2'h0,
      AIO_SRC_TIMER = 2'h1,
      AIO_SRC_EXTERNAL = 2'h2,
      AIO_SRC_RESERVED = 2'h3
   } aio_src_type;
endpackage

/* core/aio_port.sv */
// one bidirectional digital port with readback
`timescale 1ns/10ps
module aio_port
   import aio_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic wr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic is_input,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] rdata
);
   initial begin
      if (WIDTH < 1 || WIDTH > 8) $error("port width must be 1 to 8");
   end
   logic [WIDTH-1:0] latch;
   logic [WIDTH-1:0] next_latch;
   logic [WIDTH-1:0] sync1;
   logic [WIDTH-1:0] sync2;

   always_comb begin
      next_latch = latch;
      if (wr) begin
         next_latch = wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         latch <= AIO_RST_PORT[WIDTH-1:0];
         sync1 <= AIO_RST_PORT[WIDTH-1:0];
         sync2 <= AIO_RST_PORT[WIDTH-1:0];
      end else if (clk_en) begin
         latch <= next_latch;
         sync1 <= pin_in;
         sync2 <= sync1;
      end
   end

   assign pin_out = latch;
   assign pin_oe = is_input ? '0 : '1;
   assign rdata = is_input ? sync2 : latch; // RULE15
endmodule

/* core/aio_regs.sv */
// control and status register slice: output latches, trigger setup, status, interrupts, ports
//
// How it works
// RULE1 - offsets E and F carry a 12-bit code for the second output
// RULE2 - update bit clear: outputs update on own write; set: both on second write
// RULE3 - trigger config bits 1..0 select software, timer or external trigger
// RULE4 - trigger config bit 2 selects single channel or scan conversion
// RULE5 - trigger config bit 3 selects rising or falling trigger edge
// RULE6 - trigger config bit 4 selects internal or external counter 0 clock
// RULE7 - offset 12 bits 4..0 report jumpers and output ranges
// RULE8 - offset 12 bits 7..5 report fifo empty, half and full, active low
// RULE9 - offset 13 write sets four interrupt enables in bits 3..0
// RULE10 - any enabled condition raises an interrupt, any combination allowed
// RULE11 - offset 13 read returns latched causes in bits 7..4
// RULE12 - reading offset 13 clears every set cause flag
// RULE13 - offset 14 reads port a levels and drives written byte
// RULE14 - offset 15 reads port b levels and drives written byte
// RULE15 - an output port reads back its driven value
// RULE16 - direction bits take effect only when bit 7 is written as one
// RULE17 - direction bit 4 port a, bit 1 port b; one is input, default input
// RULE18 - in simultaneous mode first output data waits for next second output write
// RULE19 - host makes word accesses only at even offsets; bytes anywhere
// RULE20 - byte write at E only holds low byte; F or word write updates
// RULE21 - don't-care bits ignored and read zero; offset 16 does nothing
`timescale 1ns/10ps
module aio_regs
   import aio_pkg::*;
#(
   parameter int CODE_WIDTH = 12
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [4:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_word,
   output logic [15:0] bus_rdata,
   input wire logic first_output_wr,
   input wire logic [11:0] first_output_data,
   output logic [11:0] first_output_code,
   output logic [11:0] output_code,
   output logic [1:0] trigger_source,
   output logic scan_select,
   output logic trigger_edge_select,
   output logic counter0_clock_select,
   input wire logic bipolar_jumper,
   input wire logic single_ended_jumper,
   input wire logic gain_range_jumper,
   input wire logic first_output_range,
   input wire logic second_output_range,
   input wire logic fifo_not_empty,
   input wire logic fifo_half,
   input wire logic fifo_full,
   input wire logic conversion_done,
   input wire logic scan_done,
   output logic int_req,
   input wire logic [7:0] first_port_in,
   output logic [7:0] first_port_bits,
   output logic [7:0] first_port_oe,
   input wire logic [7:0] second_port_in,
   output logic [7:0] second_port_bits,
   output logic [7:0] second_port_oe
);
   initial begin
      if (CODE_WIDTH != 12) $error("output code width must be 12");
   end

   // ****************************************
   // access decode
   // ****************************************
   logic wr_e;
   logic wr_f;
   logic rd_int;
   assign wr_e = bus_wr && bus_addr == AIO_OFF_OUT1_LOW;
   // RULE19 a word write at even offset E also carries offset F
   assign wr_f = bus_wr && (bus_addr == AIO_OFF_OUT1_HIGH || (wr_e && bus_word));
   assign rd_int = bus_rd && bus_addr == AIO_OFF_INT;

   // ****************************************
   // analog output latches
   // ****************************************
   logic simult;
   logic [7:0] low_hold;
   logic [11:0] first_hold;
   logic first_pending;
   logic [11:0] first_code;
   logic [11:0] second_code;
   logic next_simult;
   logic [7:0] next_low_hold;
   logic [11:0] next_first_hold;
   logic next_first_pending;
   logic [11:0] next_first_code;
   logic [11:0] next_second_code;

   always_comb begin
      next_simult = simult;
      next_low_hold = low_hold;
      next_first_hold = first_hold;
      next_first_pending = first_pending;
      next_first_code = first_code;
      next_second_code = second_code;
      if (bus_wr && bus_addr == AIO_OFF_UPDATE_CFG) begin
         next_simult = bus_wdata[AIO_BIT_SIMULT]; // RULE2
      end
      if (wr_e) begin
         next_low_hold = bus_wdata[7:0]; // RULE20
      end
      if (first_output_wr) begin
         if (simult) begin
            next_first_hold = first_output_data; // RULE18
            next_first_pending = 1'b1;
         end else begin
            next_first_code = first_output_data; // RULE2
         end
      end
      if (wr_f) begin
         if (bus_word && wr_e) begin
            next_second_code = {bus_wdata[11:8], bus_wdata[7:0]}; // RULE1
         end else begin
            next_second_code = {bus_wdata[3:0], low_hold}; // RULE1
         end
         if (first_pending) begin
            next_first_code = first_hold; // RULE18
            next_first_pending = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         simult <= 1'b0;
         low_hold <= AIO_RST_PORT;
         first_hold <= AIO_RST_CODE;
         first_pending <= 1'b0;
         first_code <= AIO_RST_CODE;
         second_code <= AIO_RST_CODE;
      end else if (clk_en) begin
         simult <= next_simult;
         low_hold <= next_low_hold;
         first_hold <= next_first_hold;
         first_pending <= next_first_pending;
         first_code <= next_first_code;
         second_code <= next_second_code;
      end
   end
   assign first_output_code = first_code;
   assign output_code = second_code;

   // ****************************************
   // trigger and counter clock setup
   // ****************************************
   logic [4:0] trig;
   logic [4:0] next_trig;
   always_comb begin
      next_trig = trig;
      if (bus_wr && bus_addr == AIO_OFF_TRIGGER_CFG) begin
         next_trig = bus_wdata[4:0]; // RULE21
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         trig <= AIO_RST_TRIG;
      end else if (clk_en) begin
         trig <= next_trig;
      end
   end
   assign trigger_source = trig[1:0]; // RULE3
   assign scan_select = trig[AIO_BIT_SCAN]; // RULE4
   assign trigger_edge_select = trig[AIO_BIT_EDGE]; // RULE5
   assign counter0_clock_select = trig[AIO_BIT_CLKSEL]; // RULE6

   // ****************************************
   // status pin synchronisers
   // ****************************************
   logic [9:0] st_s1;
   logic [9:0] st_s2;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st_s1 <= '0;
         st_s2 <= '0;
      end else if (clk_en) begin
         st_s1 <= {scan_done, conversion_done, fifo_full, fifo_half, fifo_not_empty,
                   second_output_range, first_output_range, gain_range_jumper,
                   single_ended_jumper, bipolar_jumper};
         st_s2 <= st_s1;
      end
   end
   logic [7:0] status_byte;
   // RULE7 RULE8
   assign status_byte = {~st_s2[7], ~st_s2[6], st_s2[5], st_s2[4:0]};

   // ****************************************
   // interrupt enables and causes
   // ****************************************
   logic [3:0] int_en;
   logic [3:0] cause;
   logic [3:0] ev_prev;
   logic [3:0] next_int_en;
   logic [3:0] next_cause;
   logic [3:0] ev_now;
   logic [3:0] ev_rise;
   assign ev_now = {st_s2[7], st_s2[6], st_s2[9], st_s2[8]};
   assign ev_rise = ev_now & ~ev_prev;

   always_comb begin
      next_int_en = int_en;
      next_cause = cause;
      if (bus_wr && bus_addr == AIO_OFF_INT) begin
         next_int_en = bus_wdata[3:0]; // RULE9
      end
      if (rd_int) begin
         next_cause = 4'h0; // RULE12
      end
      next_cause = next_cause | (ev_rise & int_en); // RULE10
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         int_en <= AIO_RST_INT_EN;
         cause <= 4'h0;
         ev_prev <= 4'h0;
      end else if (clk_en) begin
         int_en <= next_int_en;
         cause <= next_cause;
         ev_prev <= ev_now;
      end
   end
   assign int_req = |cause; // RULE10

   // ****************************************
   // digital ports and direction
   // ****************************************
   logic dir_a;
   logic dir_b;
   logic next_dir_a;
   logic next_dir_b;
   logic [7:0] port_a_rd;
   logic [7:0] port_b_rd;
   always_comb begin
      next_dir_a = dir_a;
      next_dir_b = dir_b;
      if (bus_wr && bus_addr == AIO_OFF_DIR_CFG && bus_wdata[AIO_BIT_QUAL]) begin // RULE16
         next_dir_a = bus_wdata[AIO_BIT_DIR_A]; // RULE17
         next_dir_b = bus_wdata[AIO_BIT_DIR_B]; // RULE17
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         dir_a <= AIO_RST_DIR;
         dir_b <= AIO_RST_DIR;
      end else if (clk_en) begin
         dir_a <= next_dir_a;
         dir_b <= next_dir_b;
      end
   end

   aio_port #(.WIDTH(8)) u_port_a (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .wr(bus_wr && bus_addr == AIO_OFF_PORT_A), // RULE13
      .wdata(bus_wdata[7:0]),
      .is_input(dir_a),
      .pin_in(first_port_in),
      .pin_out(first_port_bits),
      .pin_oe(first_port_oe),
      .rdata(port_a_rd)
   );

   aio_port #(.WIDTH(8)) u_port_b (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .wr(bus_wr && ((bus_addr == AIO_OFF_PORT_B) ||
                     (bus_word && bus_addr == AIO_OFF_PORT_A))), // RULE14
      .wdata(bus_addr == AIO_OFF_PORT_B ? bus_wdata[7:0] : bus_wdata[15:8]),
      .is_input(dir_b),
      .pin_in(second_port_in),
      .pin_out(second_port_bits),
      .pin_oe(second_port_oe),
      .rdata(port_b_rd)
   );

   // ****************************************
   // read mux
   // ****************************************
   always_comb begin
      bus_rdata = 16'h0000; // RULE21
      if (bus_rd) begin
         unique case (bus_addr)
            AIO_OFF_STATUS: bus_rdata = {8'h00, status_byte}; // RULE7 RULE8
            AIO_OFF_INT: bus_rdata = {8'h00, cause, 4'h0}; // RULE11
            AIO_OFF_PORT_A: begin
               bus_rdata = {bus_word ? port_b_rd : 8'h00, port_a_rd}; // RULE13
            end
            AIO_OFF_PORT_B: bus_rdata = {8'h00, port_b_rd}; // RULE14
            default: bus_rdata = 16'h0000; // RULE21
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   read_clears_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE12
      (clk_en && rd_int && ((ev_rise & int_en) == 4'h0)) |=> (cause == 4'h0))
      else $error("cause flags not cleared by read");
   set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE10
      (clk_en && ev_rise[0] && int_en[0]) |=> (cause[0] && int_req))
      else $error("enabled event not latched");
   masked_event_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE9
      (clk_en && !int_en[1] && !cause[1] && !rd_int) |=> !cause[1])
      else $error("disabled cause was set");
   low_byte_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE20
      (clk_en && wr_e && !bus_word) |=> $stable(output_code))
      else $error("byte write at E changed output");
   second_update_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE1
      (clk_en && bus_wr && bus_addr == AIO_OFF_OUT1_HIGH) |=>
      (output_code == {$past(bus_wdata[3:0]), $past(low_hold)}))
      else $error("second output code wrong");
   simult_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE18
      (clk_en && simult && first_output_wr && !wr_f) |=> $stable(first_output_code))
      else $error("first output updated early");
   dir_qualifier_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE16
      (clk_en && bus_wr && bus_addr == AIO_OFF_DIR_CFG && !bus_wdata[7]) |=>
      ($stable(dir_a) && $stable(dir_b)))
      else $error("direction changed without qualifier");
   output_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE17
      (!dir_a |-> first_port_oe == 8'hFF) and (dir_a |-> first_port_oe == 8'h00))
      else $error("port a enable mismatch");
   readback_a: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE15
      (bus_rd && bus_addr == AIO_OFF_PORT_B && !dir_b) |-> bus_rdata[7:0] == second_port_bits)
      else $error("port b readback wrong");
endmodule

/* testbench/aio_host_model.sv */
// host processor model driving byte and word cycles on the register bus
`timescale 1ns/10ps
module aio_host_model (
   input wire logic clk_sys,
   output logic [4:0] bus_addr,
   output logic [15:0] bus_wdata,
   output logic bus_wr,
   output logic bus_rd,
   output logic bus_word
);
   initial begin
      bus_addr = 5'h00;
      bus_wdata = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_word = 1'b0;
   end
   // ****************************************
   // one bus cycle, taken at the second edge
   // ****************************************
   task automatic access(input logic [4:0] addr, input logic [15:0] data, input logic word,
      input logic rd);
      @(posedge clk_sys);
      bus_addr <= word ? {addr[4:1], 1'b0} : addr;
      bus_wdata <= word ? data : {8'h00, data[7:0]};
      bus_word <= word;
      bus_wr <= !rd;
      bus_rd <= rd;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
      bus_rd <= 1'b0;
      bus_addr <= ~addr;
      bus_wdata <= ~data;
      #1;
   endtask
endmodule

/* testbench/test_analog_io_control_registers.sv */
// self-checking bench of the analog io control register slice
`timescale 1ns/10ps
module test_analog_io_control_registers;
   import aio_pkg::*;
   logic clk_sys, rst_b, clk_en, first_output_wr, bus_wr, bus_rd, bus_word, int_req;
   logic [4:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, v, w;
   logic [11:0] first_output_data, first_output_code, output_code;
   logic [1:0] trigger_source;
   logic scan_select, trigger_edge_select, counter0_clock_select;
   logic [9:0] flags;
   logic [7:0] ext_a, ext_b, pin_a, pin_b, first_port_bits, first_port_oe;
   logic [7:0] second_port_bits, second_port_oe;
   logic [16:0] exp_q[$];
   logic [16:0] ent;
   logic [31:0] seed = 32'h000150B4;
   int num_errors = 0;
   int total_checks = 0;
   int k;
   int ev_pos[4] = '{8, 9, 6, 7};
   assign pin_a = (first_port_bits & first_port_oe) | (ext_a & ~first_port_oe);
   assign pin_b = (second_port_bits & second_port_oe) | (ext_b & ~second_port_oe);
   aio_host_model aio_host_model_i (.clk_sys(clk_sys), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_word(bus_word));
   aio_regs aio_regs_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_word(bus_word), .bus_rdata(bus_rdata), .first_output_wr(first_output_wr),
      .first_output_data(first_output_data), .first_output_code(first_output_code),
      .output_code(output_code), .trigger_source(trigger_source), .scan_select(scan_select),
      .trigger_edge_select(trigger_edge_select), .counter0_clock_select(counter0_clock_select),
      .bipolar_jumper(flags[0]), .single_ended_jumper(flags[1]), .gain_range_jumper(flags[2]),
      .first_output_range(flags[3]), .second_output_range(flags[4]),
      .fifo_not_empty(flags[5]), .fifo_half(flags[6]), .fifo_full(flags[7]),
      .conversion_done(flags[8]), .scan_done(flags[9]), .int_req(int_req),
      .first_port_in(pin_a), .first_port_bits(first_port_bits), .first_port_oe(first_port_oe),
      .second_port_in(pin_b), .second_port_bits(second_port_bits),
      .second_port_oe(second_port_oe));
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[15:0];
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t: output %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic wd);
      aio_host_model_i.access(a, d, wd, 1'b0);
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic wd);
      exp_q.push_back({wd, e});
      aio_host_model_i.access(a, 16'h0000, wd, 1'b1);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic first_pulse(input logic [11:0] d);
      @(posedge clk_sys);
      first_output_data <= d;
      first_output_wr <= 1'b1;
      @(posedge clk_sys);
      first_output_wr <= 1'b0;
      #1;
   endtask
   task automatic end_of_test();
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ****************************************
   // read data monitor
   // ****************************************
   always @(posedge clk_sys) begin
      if (bus_rd === 1'b1) begin
         ent = exp_q.pop_front();
         total_checks++;
         if ((ent[16] ? bus_rdata : {8'h00, bus_rdata[7:0]}) !== ent[15:0]) begin
            num_errors++;
            $display("[ERR] %0t: read %h expected %h", $time, bus_rdata, ent[15:0]);
         end
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (50000) @(posedge clk_sys);
      num_errors++;
      end_of_test();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      first_output_wr = 1'b0;
      first_output_data = 12'h000;
      flags = 10'h000;
      ext_a = 8'h00;
      ext_b = 8'h00;
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      v = rnd();
      ext_a <= v[7:0];
      ext_b <= v[15:8];
      cyc(1);
      chk(first_port_oe, 16'h0000);
      chk(second_port_oe, 16'h0000);
      w = rnd();
      wr(AIO_OFF_OUT1_LOW, w, 1'b0);
      chk(output_code, 16'h0000);
      wr(AIO_OFF_OUT1_HIGH, {8'h00, w[15:8]}, 1'b0);
      chk(output_code, {4'h0, w[11:0]});
      w = rnd();
      wr(AIO_OFF_OUT1_LOW, w, 1'b1);
      chk(output_code, {4'h0, w[11:0]});
      first_pulse(w[11:0]);
      chk(first_output_code, {4'h0, w[11:0]});
      wr(AIO_OFF_UPDATE_CFG, 16'h0001, 1'b0);
      v = rnd();
      first_pulse(v[11:0]);
      cyc(3);
      chk(first_output_code, {4'h0, w[11:0]});
      wr(AIO_OFF_OUT1_LOW, 16'h00A5, 1'b0);
      chk(first_output_code, {4'h0, w[11:0]});
      wr(AIO_OFF_OUT1_HIGH, 16'h003C, 1'b0);
      chk(first_output_code, {4'h0, v[11:0]});
      chk(output_code, 16'h0CA5);
      wr(AIO_OFF_UPDATE_CFG, 16'h0000, 1'b0);
      for (k = 0; k < 32; k++) begin
         v = rnd();
         wr(AIO_OFF_TRIGGER_CFG, {8'h00, v[7:5], k[4:0]}, 1'b0);
         chk(trigger_source, k[1:0]);
         chk(scan_select, k[2]);
         chk(trigger_edge_select, k[3]);
         chk(counter0_clock_select, k[4]);
      end
      for (k = 0; k < 4; k++) begin
         v = rnd();
         @(posedge clk_sys);
         flags[7:0] <= v[7:0];
         cyc(4);
         rd(AIO_OFF_STATUS, {8'h00, ~v[7], ~v[6], v[5:0]}, 1'b0);
      end
      @(posedge clk_sys);
      flags <= 10'h000;
      cyc(4);
      for (k = 0; k < 4; k++) begin
         wr(AIO_OFF_INT, 16'h00F0 | (16'h0001 << k), 1'b0);
         @(posedge clk_sys);
         flags[ev_pos[k]] <= 1'b1;
         flags[ev_pos[(k + 1) % 4]] <= 1'b1;
         cyc(6);
         chk(int_req, 16'h0001);
         @(posedge clk_sys);
         flags <= 10'h000;
         rd(AIO_OFF_INT, 16'h0010 << k, 1'b0);
         cyc(2);
         chk(int_req, 16'h0000);
         rd(AIO_OFF_INT, 16'h0000, 1'b0);
      end
      wr(AIO_OFF_INT, 16'h000F, 1'b0);
      @(posedge clk_sys);
      flags[9:6] <= 4'hF;
      cyc(6);
      rd(AIO_OFF_INT, 16'h00F0, 1'b0);
      wr(AIO_OFF_DIR_CFG, 16'h0000, 1'b0);
      chk(first_port_oe, 16'h0000);
      wr(AIO_OFF_DIR_CFG, 16'h0080, 1'b0);
      chk(first_port_oe, 16'h00FF);
      chk(second_port_oe, 16'h00FF);
      v = rnd();
      wr(AIO_OFF_PORT_A, v, 1'b1);
      chk(first_port_bits, v[7:0]);
      chk(second_port_bits, v[15:8]);
      cyc(3);
      rd(AIO_OFF_PORT_A, v, 1'b1);
      rd(AIO_OFF_PORT_B, v[15:8], 1'b0);
      wr(AIO_OFF_DIR_CFG, 16'h0090, 1'b0);
      chk({first_port_oe, second_port_oe}, 16'h00FF);
      cyc(3);
      rd(AIO_OFF_PORT_A, ext_a, 1'b0);
      wr(AIO_OFF_DIR_CFG, 16'h0082, 1'b0);
      chk({first_port_oe, second_port_oe}, 16'hFF00);
      cyc(3);
      rd(AIO_OFF_PORT_B, ext_b, 1'b0);
      wr(AIO_OFF_UNUSED, 16'h00FF, 1'b0);
      rd(AIO_OFF_UNUSED, 16'h0000, 1'b0);
      chk(output_code, 16'h0CA5);
      @(posedge clk_sys);
      clk_en <= 1'b0;
      wr(AIO_OFF_OUT1_LOW, 16'h0F0F, 1'b1);
      chk(output_code, 16'h0CA5);
      @(posedge clk_sys);
      clk_en <= 1'b1;
      rst_b <= 1'b0;
      cyc(2);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      cyc(1);
      chk(output_code, 16'h0000);
      chk({first_port_oe, second_port_oe}, 16'h0000);
      cyc(2);
      end_of_test();
   end
endmodule
